// ---- hw/seq_util_defines.svh ----
// Constants for the sequencer utility command block
`ifndef SEQ_UTIL_DEFINES_SVH
`define SEQ_UTIL_DEFINES_SVH

// ****************************************
// Opcodes
// ****************************************
`define OP_CONFIG_READ 8'h2E
`define OP_BUFFER_WRITE 8'hD1
`define OP_BUFFER_READ 8'h1D
`define OP_DELAY 8'hDD

// ****************************************
// Field positions and reset values
// ****************************************
`define BUF_ENABLE_BIT 7
`define DELAY_FIELD_MSB 3
`define DELAY_FIELD_LSB 0
`define BUF_ENABLE_RESET 1'b0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
`define DELAY_UNIT_NS 1000000
`define DELAY_UNIT_CYCLES (`DELAY_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- hw/seq_util_pkg.sv ----
// Types shared by the sequencer utility command block
package seq_util_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_fetch,
    st_decode,
    st_cfg_hi,
    st_cfg_lo,
    st_param_fetch,
    st_param_use,
    st_buf_read,
    st_delay,
    st_next
  } seq_state_type;

endpackage

// ---- hw/cmd_mem_if.sv ----
// Port bundle between sequencer and command list memory
`timescale 1ns/1ps
interface cmd_mem_if #(parameter int ADDR_W = 9);
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;

  modport master (output addr, output wdata, output we, input rdata);
  modport slave (input addr, input wdata, input we, output rdata);
endinterface

// ---- hw/cmd_list_mem.sv ----
// Command list memory with registered read data
`timescale 1ns/1ps
module cmd_list_mem #(
  parameter int DEPTH = 512,
  parameter int ADDR_W = 9
) (
  // Clock
  input wire logic clk_sys,
  // Access port
  cmd_mem_if.slave port
);

  logic [7:0] store [DEPTH];
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = store[port.addr];
  end

  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= next_rdata;
  end

endmodule // cmd_list_mem

// ---- hw/sequencer_gpio_delay_cmds.sv ----
// Sequencer executing configuration read, input buffer and delay commands
`timescale 1ns/1ps
`include "seq_util_defines.svh"
module sequencer_gpio_delay_cmds
  import seq_util_pkg::*;
#(
  parameter int DEPTH = 512,
  parameter int ADDR_W = 9,
  parameter int PIN_COUNT = 2,
  parameter int unsigned DELAY_UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host side command list access
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_we,
  output logic [7:0] host_rdata,
  // Sequence control
  input wire logic seq_start,
  input wire logic [ADDR_W:0] seq_length,
  output logic seq_busy,
  output logic seq_done,
  output logic seq_error,
  // Pin configuration and status
  input wire logic [7:0] pin_config_high_byte,
  input wire logic [7:0] pin_config_low_byte,
  input wire logic spi_mode,
  input wire logic [PIN_COUNT-1:0] pin_i2c_owned,
  input wire logic [PIN_COUNT-1:0] pin_level,
  input wire logic function_cmd_active,
  output logic [PIN_COUNT-1:0] input_buffer_on
);

  cmd_mem_if #(.ADDR_W(ADDR_W)) mem ();

  cmd_list_mem #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_mem (
    .clk_sys(clk_sys),
    .port(mem.slave)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W:0] base, input int offs);
    logic [ADDR_W:0] sum;
    sum = base + (ADDR_W+1)'(offs);
    return sum[ADDR_W-1:0];
  endfunction

  function automatic logic known_op(input logic [7:0] op);
    return (op == `OP_CONFIG_READ) || (op == `OP_BUFFER_WRITE) ||
           (op == `OP_BUFFER_READ) || (op == `OP_DELAY);
  endfunction

  // ****************************************
  // State
  // ****************************************
  seq_state_type state, next_state;
  logic [ADDR_W:0] ptr, next_ptr;
  logic [ADDR_W:0] length, next_length;
  logic [7:0] opcode, next_opcode;
  logic gpio_input_buffer, next_gpio_input_buffer;
  logic [31:0] unit_count, next_unit_count;
  logic [15:0] units_left, next_units_left;
  logic next_seq_busy, next_seq_done, next_seq_error;
  logic [PIN_COUNT-1:0] next_input_buffer_on;
  logic [7:0] read_byte;
  logic [3:0] delay_exp;

  // Report only non-I2C pin levels
  always_comb begin
    read_byte = 8'h00;
    read_byte[`BUF_ENABLE_BIT] = gpio_input_buffer;
    for (int i = 0; i < PIN_COUNT; i++) begin
      read_byte[i] = pin_level[i] & ~pin_i2c_owned[i];
    end
  end

  assign delay_exp = mem.rdata[`DELAY_FIELD_MSB:`DELAY_FIELD_LSB];

  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_length = length;
    next_opcode = opcode;
    next_gpio_input_buffer = gpio_input_buffer;
    next_unit_count = unit_count;
    next_units_left = units_left;
    next_seq_busy = 1'b1;
    next_seq_done = 1'b0;
    next_seq_error = seq_error;
    mem.addr = host_addr;
    mem.wdata = host_wdata;
    mem.we = 1'b0;
    case (state)
      st_idle: begin
        next_seq_busy = 1'b0;
        mem.we = host_we;
        if (seq_start) begin
          next_state = (seq_length == '0) ? st_next : st_fetch;
          next_ptr = '0;
          next_length = seq_length;
          next_seq_error = 1'b0;
          next_seq_busy = 1'b1;
        end
      end
      st_fetch: begin
        mem.addr = at(ptr, 0);
        next_state = st_decode;
      end
      st_decode: begin
        next_opcode = mem.rdata;
        if (!known_op(mem.rdata)) begin
          next_seq_error = 1'b1;
          next_ptr = length;
          next_state = st_next;
        end else if (mem.rdata == `OP_CONFIG_READ) begin
          next_state = st_cfg_hi;
        end else if (mem.rdata == `OP_BUFFER_READ) begin
          next_state = st_buf_read;
        end else begin
          next_state = st_param_fetch;
        end
      end
      st_cfg_hi: begin
        mem.addr = at(ptr, 1);
        mem.wdata = pin_config_high_byte;
        mem.we = 1'b1;
        next_state = st_cfg_lo;
      end
      st_cfg_lo: begin
        mem.addr = at(ptr, 2);
        mem.wdata = pin_config_low_byte;
        mem.we = 1'b1;
        next_ptr = ptr + (ADDR_W+1)'(3);
        next_state = st_next;
      end
      st_buf_read: begin
        mem.addr = at(ptr, 1);
        mem.wdata = read_byte;
        mem.we = !spi_mode;
        next_ptr = ptr + (ADDR_W+1)'(2);
        next_state = st_next;
      end
      st_param_fetch: begin
        mem.addr = at(ptr, 1);
        next_state = st_param_use;
      end
      st_param_use: begin
        next_ptr = ptr + (ADDR_W+1)'(2);
        if (opcode == `OP_BUFFER_WRITE) begin
          if (!spi_mode) begin
            next_gpio_input_buffer = mem.rdata[`BUF_ENABLE_BIT];
          end
          next_state = st_next;
        end else begin
          next_units_left = 16'h0001 << delay_exp;
          next_unit_count = '0;
          next_state = st_delay;
        end
      end
      st_delay: begin
        if (unit_count == DELAY_UNIT_CYCLES - 1) begin
          next_unit_count = '0;
          next_units_left = units_left - 16'h0001;
          if (units_left == 16'h0001) begin
            next_state = st_next;
          end
        end else begin
          next_unit_count = unit_count + 32'h0000_0001;
        end
      end
      st_next: begin
        if (ptr >= length) begin
          next_state = st_idle;
          next_seq_done = 1'b1;
          next_seq_busy = 1'b0;
        end else begin
          next_state = st_fetch;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_input_buffer_on[i] = function_cmd_active |
                                (next_gpio_input_buffer & ~pin_i2c_owned[i] & ~spi_mode);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      ptr <= '0;
      length <= '0;
      opcode <= 8'h00;
      gpio_input_buffer <= `BUF_ENABLE_RESET;
      unit_count <= '0;
      units_left <= '0;
      seq_busy <= 1'b0;
      seq_done <= 1'b0;
      seq_error <= 1'b0;
      input_buffer_on <= '0;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      length <= next_length;
      opcode <= next_opcode;
      gpio_input_buffer <= next_gpio_input_buffer;
      unit_count <= next_unit_count;
      units_left <= next_units_left;
      seq_busy <= next_seq_busy;
      seq_done <= next_seq_done;
      seq_error <= next_seq_error;
      input_buffer_on <= next_input_buffer_on;
    end
  end

  assign host_rdata = mem.rdata;

endmodule // sequencer_gpio_delay_cmds

// ---- testbench/seq_cmds_props.sv ----
// Port assertions for the sequencer utility command block
`timescale 1ns/1ps
module seq_cmds_checker #(
  parameter int PIN_COUNT = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Sequence control
  input wire logic seq_start,
  input wire logic seq_busy,
  input wire logic seq_done,
  input wire logic seq_error,
  // Pin status
  input wire logic spi_mode,
  input wire logic [PIN_COUNT-1:0] pin_i2c_owned,
  input wire logic function_cmd_active,
  input wire logic [PIN_COUNT-1:0] input_buffer_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_sets_busy: assert property (seq_start && !seq_busy |=> seq_busy)
    else $error("busy missing after start");
  a_idle_stays_idle: assert property (!seq_busy && !seq_start |=> !seq_busy)
    else $error("busy without start");
  a_done_ends_busy: assert property (seq_done |-> !seq_busy && $past(seq_busy))
    else $error("done not at end of busy");
  a_busy_fall_done: assert property ($fell(seq_busy) |-> seq_done)
    else $error("busy fell without done");
  a_done_one_cycle: assert property (seq_done |=> !seq_done)
    else $error("done longer than one cycle");
  a_error_holds: assert property (seq_error && !seq_start |=> seq_error)
    else $error("error dropped without start");
  a_forced_buffers: assert property (function_cmd_active |=> &input_buffer_on)
    else $error("buffers not forced on");
  a_i2c_pins_off: assert property (!function_cmd_active |=>
    (input_buffer_on & $past(pin_i2c_owned)) == '0)
    else $error("buffer on for shared pin");
  a_spi_buffers_off: assert property (!function_cmd_active && spi_mode |=>
    input_buffer_on == '0)
    else $error("buffer on in serial mode");
endmodule // seq_cmds_checker

bind sequencer_gpio_delay_cmds seq_cmds_checker #(.PIN_COUNT(PIN_COUNT)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .seq_start(seq_start), .seq_busy(seq_busy),
  .seq_done(seq_done), .seq_error(seq_error), .spi_mode(spi_mode),
  .pin_i2c_owned(pin_i2c_owned), .function_cmd_active(function_cmd_active),
  .input_buffer_on(input_buffer_on));

// ---- testbench/pin_side_model.sv ----
// Pin side model: configuration bytes and sampled pin levels
`timescale 1ns/1ps
module pin_side_model #(
  parameter logic [7:0] CFG_HI = 8'hA5,
  parameter logic [7:0] CFG_LO = 8'h3C,
  parameter logic [1:0] LEVEL = 2'h3
) (
  // Pin state
  output logic [7:0] pin_config_high_byte,
  output logic [7:0] pin_config_low_byte,
  output logic [1:0] pin_level
);
  assign pin_config_high_byte = CFG_HI;
  assign pin_config_low_byte = CFG_LO;
  // Pins pulled to a defined level while floating
  assign pin_level = LEVEL;
endmodule // pin_side_model

// ---- testbench/test_sequencer_gpio_delay_cmds.sv ----
// Self-checking bench for the sequencer utility command block
`timescale 1ns/1ps
module test_sequencer_gpio_delay_cmds;
  localparam logic [7:0] CFG_HI = 8'hA5;
  localparam logic [7:0] CFG_LO = 8'h3C;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [8:0] host_addr = 9'h000;
  logic [7:0] host_wdata = 8'h00;
  logic host_we = 1'h0;
  logic seq_start = 1'h0;
  logic [9:0] seq_length = 10'h000;
  logic spi_mode = 1'h0;
  logic [1:0] pin_i2c_owned = 2'h2;
  logic function_cmd_active = 1'h0;
  logic [7:0] host_rdata, cfg_hi, cfg_lo;
  logic [1:0] pin_level, input_buffer_on;
  logic seq_busy, seq_done, seq_error;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int busy_cycles = 0;

  always #50 clk_sys = ~clk_sys;

  pin_side_model #(.CFG_HI(CFG_HI), .CFG_LO(CFG_LO), .LEVEL(2'h3)) u_pins (
    .pin_config_high_byte(cfg_hi), .pin_config_low_byte(cfg_lo), .pin_level(pin_level));

  sequencer_gpio_delay_cmds #(.DELAY_UNIT_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_we(host_we), .host_rdata(host_rdata), .seq_start(seq_start),
    .seq_length(seq_length), .seq_busy(seq_busy), .seq_done(seq_done),
    .seq_error(seq_error), .pin_config_high_byte(cfg_hi), .pin_config_low_byte(cfg_lo),
    .spi_mode(spi_mode), .pin_i2c_owned(pin_i2c_owned), .pin_level(pin_level),
    .function_cmd_active(function_cmd_active), .input_buffer_on(input_buffer_on));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic load(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    host_wdata <= d;
    host_we <= 1'h1;
    @(posedge clk_sys);
    host_we <= 1'h0;
  endtask

  task automatic read(input logic [8:0] a, input string name, input logic [7:0] exp);
    @(posedge clk_sys);
    host_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 check(name, host_rdata, exp);
  endtask

  task automatic run(input logic [9:0] len);
    @(posedge clk_sys);
    seq_start <= 1'h1;
    seq_length <= len;
    @(posedge clk_sys);
    seq_start <= 1'h0;
    busy_cycles = 0;
    for (int i = 0; i < 300; i++) begin
      #1;
      if (seq_done === 1'h1) break;
      if (seq_busy === 1'h1) busy_cycles++;
      @(posedge clk_sys);
    end
    check("seq_done", {7'h00, seq_done}, 8'h01);
  endtask

  // ****************************************
  // Timeout and tests
  // ****************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    load(0, 8'h2E); load(1, 8'hFF); load(2, 8'hFF);
    run(3);
    read(1, "cfg_hi", CFG_HI);
    read(2, "cfg_lo", CFG_LO);
    load(0, 8'hD1); load(1, 8'h7F); load(2, 8'h1D); load(3, 8'hFF);
    load(4, 8'hD1); load(5, 8'h80); load(6, 8'h1D); load(7, 8'hFF);
    run(8);
    read(3, "buf_low_bits", 8'h01);
    read(7, "buf_read", 8'h81);
    check("pins_on", {6'h00, input_buffer_on}, 8'h01);
    @(posedge clk_sys);
    function_cmd_active <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1 check("forced", {6'h00, input_buffer_on}, 8'h03);
    @(posedge clk_sys);
    function_cmd_active <= 1'h0;
    spi_mode <= 1'h1;
    load(0, 8'hD1); load(1, 8'h00); load(2, 8'h1D); load(3, 8'hFF);
    run(4);
    read(3, "spi_read", 8'hFF);
    check("spi_pins", {6'h00, input_buffer_on}, 8'h00);
    @(posedge clk_sys);
    spi_mode <= 1'h0;
    load(0, 8'h1D); load(1, 8'hFF);
    run(2);
    read(1, "spi_kept", 8'h81);
    load(0, 8'hDD); load(1, 8'hF1); load(2, 8'hDD); load(3, 8'h02);
    fork
      run(4);
      begin
        repeat (6) @(posedge clk_sys);
        load(0, 8'h00);
      end
    join
    check("delay_cycles", busy_cycles[7:0], 8'h22);
    read(0, "busy_write", 8'hDD);
    load(0, 8'h77);
    run(1);
    check("seq_error", {7'h00, seq_error}, 8'h01);
    load(0, 8'hDD); load(1, 8'h00);
    run(2);
    check("error_cleared", {7'h00, seq_error}, 8'h00);
    check("delay_min", busy_cycles[7:0], 8'h09);
    finish_test();
  end
endmodule // test_sequencer_gpio_delay_cmds
